// ---- design/gcs_pkg.sv ----
package gcs_pkg;
	// register addresses of the serial host interface
	localparam int ADDR_W = 7;
	localparam logic [6:0] ADDR_GCONF = 7'h00;
	localparam logic [6:0] ADDR_GLOBAL_STATUS_FLAGS = 7'h01;
	localparam logic [6:0] ADDR_WCNT = 7'h02;
	localparam logic [6:0] ADDR_TARGET = 7'h2D;

	// upper configuration bit positions
	localparam int POS_FAULT_PP = 12;
	localparam int POS_POS_PP = 13;
	localparam int POS_SMALL_HYST = 14;
	localparam int POS_STOP_EN = 15;
	localparam int POS_DIRECT = 16;
	localparam int POS_PROBE = 17;
	localparam int CFG_LSB = POS_FAULT_PP;
	localparam int CFG_W = POS_PROBE - POS_FAULT_PP + 1;
	localparam logic [5:0] CFG_RESET = 6'h00;

	// status flag positions and reset value
	localparam int FLAG_W = 3;
	localparam int POS_RESET_FLAG = 0;
	localparam int POS_DRV_ERR = 1;
	localparam int POS_PUMP_UV = 2;
	localparam logic [2:0] FLAGS_RESET = 3'h1;

	// write counter
	localparam int WCNT_W = 8;
	localparam logic [7:0] WCNT_RESET = 8'h00;

	// direct coil current fields inside the target position register
	localparam int COIL_W = 9;
	localparam int COIL_A_LSB = 0;
	localparam int COIL_B_LSB = 16;
	localparam logic [8:0] COIL_RESET = 9'h000;

	// standstill current field and scaling
	localparam int HOLD_W = 5;
	localparam int HOLD_SHIFT = 5;
	localparam int PROBE_SEL_W = 2;

	// hysteresis of step frequency comparison: 1/16 or 1/32
	localparam int HYST_SHIFT_WIDE = 4;
	localparam int HYST_SHIFT_NARROW = 5;
	localparam int PERIOD_W = 16;

	// pin filter
	localparam int PIN_COUNT = 4;
	localparam logic [3:0] PIN_RESET = 4'h0;
endpackage

// ---- design/pin_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
	parameter int WIDTH = gcs_pkg::PIN_COUNT
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// pins in, filtered levels out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level
);
	import gcs_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} filt_t;

	filt_t st_r;
	filt_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// accept a level only when the last two stages agree
		for (int i = 0; i < WIDTH; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.lvl[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.lvl;
endmodule
`default_nettype wire

// ---- design/global_config_status_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module global_config_status_bank (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// register access from the serial host interface
	input wire logic host_is_uart,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [gcs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// protection inputs, asynchronous levels
	input wire logic over_temp_in,
	input wire logic short_in,
	input wire logic pump_uv_in,
	// encoder-A / step input pin
	input wire logic encoder_a_step_in_pin,
	// diagnostic sources, same clock
	input wire logic fault_event,
	input wire logic position_event,
	// diagnostic pins
	input wire logic diagnostic_pin_zero_i,
	output logic diagnostic_pin_zero_o,
	output logic diagnostic_pin_zero_oe,
	input wire logic diagnostic_pin_one_i,
	output logic diagnostic_pin_one_o,
	output logic diagnostic_pin_one_oe,
	// current settings and sequencer currents
	input wire logic [gcs_pkg::HOLD_W-1:0] standstill_current_field,
	input wire logic signed [gcs_pkg::COIL_W-1:0] seq_coil_a,
	input wire logic signed [gcs_pkg::COIL_W-1:0] seq_coil_b,
	output logic signed [gcs_pkg::COIL_W-1:0] coil_a_cmd,
	output logic signed [gcs_pkg::COIL_W-1:0] coil_b_cmd,
	// chopper regulation control
	input wire logic low_velocity,
	output logic velocity_regulation_en,
	output logic auto_regulation_en,
	// step frequency comparison
	input wire logic [gcs_pkg::PERIOD_W-1:0] step_period_meas,
	input wire logic [gcs_pkg::PERIOD_W-1:0] step_period_ref,
	output logic step_freq_match,
	// sequencer and driver control
	output logic sequencer_halt,
	output logic driver_enable,
	// analog probe on encoder-N pin
	output logic encoder_n_pin_probe_en,
	output logic [gcs_pkg::PROBE_SEL_W-1:0] encoder_n_pin_probe_sel
);
	import gcs_pkg::*;

	typedef struct packed {
		logic [CFG_W-1:0] cfg;
		logic [FLAG_W-1:0] flags;
		logic [WCNT_W-1:0] wcnt;
		logic [COIL_W-1:0] tgt_a;
		logic [COIL_W-1:0] tgt_b;
		logic [31:0] rdata;
		logic rvalid;
		logic [COIL_W-1:0] cur_a;
		logic [COIL_W-1:0] cur_b;
		logic freq_match;
		logic halt;
		logic drv_en;
		logic d0_o;
		logic d0_oe;
		logic d1_o;
		logic d1_oe;
	} bank_t;

	bank_t st_r;
	bank_t st_nxt;
	logic [PIN_COUNT-1:0] pins;
	logic enc_a_f;
	logic over_temp_f;
	logic short_f;
	logic pump_uv_f;
	logic fault_pp;
	logic pos_pp;
	logic small_hyst;
	logic stop_en;
	logic direct;
	logic probe;
	logic wr_cfg;
	logic wr_flags;
	logic wr_tgt;

	pin_filter #(
		.WIDTH(PIN_COUNT)
	) u_pins (
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.pin_in({pump_uv_in, short_in, over_temp_in, encoder_a_step_in_pin}),
		.level(pins)
	);

	assign enc_a_f = pins[0];
	assign over_temp_f = pins[1];
	assign short_f = pins[2];
	assign pump_uv_f = pins[3];

	assign fault_pp = st_r.cfg[POS_FAULT_PP-CFG_LSB];
	assign pos_pp = st_r.cfg[POS_POS_PP-CFG_LSB];
	assign small_hyst = st_r.cfg[POS_SMALL_HYST-CFG_LSB];
	assign stop_en = st_r.cfg[POS_STOP_EN-CFG_LSB];
	assign direct = st_r.cfg[POS_DIRECT-CFG_LSB];
	assign probe = st_r.cfg[POS_PROBE-CFG_LSB];

	assign wr_cfg = reg_wr && reg_addr == ADDR_GCONF;
	assign wr_flags = reg_wr && reg_addr == ADDR_GLOBAL_STATUS_FLAGS;
	assign wr_tgt = reg_wr && reg_addr == ADDR_TARGET;

	// signed coil current times (hold+1)/32
	function automatic logic [COIL_W-1:0] scale_coil(
		input logic [COIL_W-1:0] coil,
		input logic [HOLD_W-1:0] hold
	);
		logic signed [15:0] prod;
		prod = 16'($signed(coil) * $signed({1'b0, hold} + 7'sh01));
		return prod[HOLD_SHIFT+COIL_W-1:HOLD_SHIFT];
	endfunction

	// difference within ref/2^shift
	function automatic logic within_hyst(
		input logic [PERIOD_W-1:0] meas,
		input logic [PERIOD_W-1:0] ref_p,
		input logic narrow
	);
		logic [PERIOD_W-1:0] diff;
		logic [PERIOD_W-1:0] band;
		diff = (meas > ref_p) ? PERIOD_W'(meas - ref_p) : PERIOD_W'(ref_p - meas);
		band = narrow ? (ref_p >> HYST_SHIFT_NARROW) : (ref_p >> HYST_SHIFT_WIDE);
		return diff <= band;
	endfunction

	// one diagnostic pin: open-drain active low or push-pull active high
	function automatic logic [1:0] pin_drive(
		input logic push_pull,
		input logic active
	);
		if (push_pull) begin
			return {active, 1'b1};
		end
		return {1'b0, active};
	endfunction

	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;

		// configuration and target fields
		if (wr_cfg) begin
			st_nxt.cfg = reg_wdata[POS_PROBE:CFG_LSB];
		end
		if (wr_tgt) begin
			st_nxt.tgt_a = reg_wdata[COIL_A_LSB+COIL_W-1:COIL_A_LSB];
			st_nxt.tgt_b = reg_wdata[COIL_B_LSB+COIL_W-1:COIL_B_LSB];
		end

		// flags: write one clears, zero keeps, a new event wins
		if (wr_flags && reg_wdata[POS_RESET_FLAG]) begin
			st_nxt.flags[POS_RESET_FLAG] = 1'b0;
		end
		if (wr_flags && reg_wdata[POS_DRV_ERR] && !over_temp_f) begin
			st_nxt.flags[POS_DRV_ERR] = 1'b0;
		end
		if (wr_flags && reg_wdata[POS_PUMP_UV]) begin
			st_nxt.flags[POS_PUMP_UV] = 1'b0;
		end
		if (over_temp_f || short_f) begin
			st_nxt.flags[POS_DRV_ERR] = 1'b1;
		end
		if (pump_uv_f) begin
			st_nxt.flags[POS_PUMP_UV] = 1'b1;
		end

		// writes to any address, mapped or not, counted only under the single-wire host
		if (reg_wr && host_is_uart) begin
			st_nxt.wcnt = WCNT_W'(st_r.wcnt + 8'h01);
		end

		// read port; reads change no state
		if (reg_rd) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = 32'h0000_0000;
			unique case (reg_addr)
				ADDR_GCONF: st_nxt.rdata[POS_PROBE:CFG_LSB] = st_r.cfg;
				ADDR_GLOBAL_STATUS_FLAGS: st_nxt.rdata[FLAG_W-1:0] = st_r.flags;
				ADDR_WCNT: st_nxt.rdata[WCNT_W-1:0] = st_r.wcnt;
				ADDR_TARGET: begin
					st_nxt.rdata[COIL_A_LSB+COIL_W-1:COIL_A_LSB] = st_r.tgt_a;
					st_nxt.rdata[COIL_B_LSB+COIL_W-1:COIL_B_LSB] = st_r.tgt_b;
				end
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// coil currents
		if (direct) begin
			st_nxt.cur_a = scale_coil(st_r.tgt_a, standstill_current_field);
			st_nxt.cur_b = scale_coil(st_r.tgt_b, standstill_current_field);
		end else begin
			st_nxt.cur_a = seq_coil_a;
			st_nxt.cur_b = seq_coil_b;
		end

		st_nxt.freq_match = within_hyst(step_period_meas, step_period_ref, small_hyst);
		st_nxt.halt = stop_en && enc_a_f;
		// shutdown held while the driver error flag stands or pump is low
		st_nxt.drv_en = !pump_uv_f && !st_r.flags[POS_DRV_ERR];
		{st_nxt.d0_o, st_nxt.d0_oe} = pin_drive(fault_pp, fault_event);
		{st_nxt.d1_o, st_nxt.d1_oe} = pin_drive(pos_pp, position_event);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.cfg <= CFG_RESET;
			st_r.flags <= FLAGS_RESET;
			st_r.wcnt <= WCNT_RESET;
			st_r.tgt_a <= COIL_RESET;
			st_r.tgt_b <= COIL_RESET;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;
	assign coil_a_cmd = st_r.cur_a;
	assign coil_b_cmd = st_r.cur_b;
	assign step_freq_match = st_r.freq_match;
	assign sequencer_halt = st_r.halt;
	assign driver_enable = st_r.drv_en;
	assign diagnostic_pin_zero_o = st_r.d0_o;
	assign diagnostic_pin_zero_oe = st_r.d0_oe;
	assign diagnostic_pin_one_o = st_r.d1_o;
	assign diagnostic_pin_one_oe = st_r.d1_oe;
	assign velocity_regulation_en = !direct;
	assign auto_regulation_en = !direct || low_velocity;
	assign encoder_n_pin_probe_en = probe;
	assign encoder_n_pin_probe_sel = standstill_current_field[PROBE_SEL_W-1:0];

	logic unused_pins;
	assign unused_pins = diagnostic_pin_zero_i ^ diagnostic_pin_one_i;
endmodule
`default_nettype wire

// ---- bench/gcs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcs_monitor (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// host port
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	// diagnostic pins
	input wire logic fault_event,
	input wire logic position_event,
	input wire logic diagnostic_pin_zero_o,
	input wire logic diagnostic_pin_zero_oe,
	input wire logic diagnostic_pin_one_o,
	input wire logic diagnostic_pin_one_oe,
	// currents and regulation
	input wire logic [gcs_pkg::HOLD_W-1:0] standstill_current_field,
	input wire logic signed [gcs_pkg::COIL_W-1:0] seq_coil_a,
	input wire logic signed [gcs_pkg::COIL_W-1:0] coil_a_cmd,
	input wire logic low_velocity,
	input wire logic velocity_regulation_en,
	input wire logic auto_regulation_en,
	input wire logic [gcs_pkg::PROBE_SEL_W-1:0] encoder_n_pin_probe_sel,
	// step comparison
	input wire logic [gcs_pkg::PERIOD_W-1:0] step_period_meas,
	input wire logic [gcs_pkg::PERIOD_W-1:0] step_period_ref,
	input wire logic step_freq_match,
	// protection
	input wire logic over_temp_in,
	input wire logic pump_uv_in,
	input wire logic driver_enable
);
	import gcs_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence hot_s; (ce && over_temp_in)[*6]; endsequence
	sequence pump_s; (ce && pump_uv_in)[*6]; endsequence
	AST_RVALID: assert property (ce && reg_rd |=> reg_rvalid) else $error("read without valid");
	AST_DIAG0: assert property (ce && (diagnostic_pin_zero_o || !diagnostic_pin_zero_oe)
		|-> diagnostic_pin_zero_oe == $past(fault_event)) else $error("fault pin drive wrong");
	AST_DIAG1: assert property (ce && (diagnostic_pin_one_o || !diagnostic_pin_one_oe)
		|-> diagnostic_pin_one_oe == $past(position_event)) else $error("position pin drive wrong");
	AST_AUTO: assert property (auto_regulation_en == (velocity_regulation_en || low_velocity))
		else $error("auto regulation wrong");
	AST_PROBE: assert property (encoder_n_pin_probe_sel == standstill_current_field[1:0])
		else $error("probe select wrong");
	AST_HOT: assert property (hot_s |=> !driver_enable) else $error("driver on while hot");
	AST_PUMP: assert property (pump_s |=> !driver_enable) else $error("driver on in undervoltage");
	AST_MATCH: assert property (ce && (step_period_meas > step_period_ref ? step_period_meas - step_period_ref
		: step_period_ref - step_period_meas) > (step_period_ref >> HYST_SHIFT_WIDE) |=> !step_freq_match)
		else $error("match outside hysteresis");
	AST_COIL: assert property (ce && velocity_regulation_en |=> coil_a_cmd == $past(seq_coil_a))
		else $error("normal coil path wrong");
endmodule
bind global_config_status_bank gcs_monitor i_gcs_monitor (.mclk, .resetn, .ce, .reg_rd, .reg_rvalid,
	.fault_event, .position_event, .diagnostic_pin_zero_o, .diagnostic_pin_zero_oe, .diagnostic_pin_one_o,
	.diagnostic_pin_one_oe, .standstill_current_field, .seq_coil_a, .coil_a_cmd, .low_velocity,
	.velocity_regulation_en, .auto_regulation_en, .encoder_n_pin_probe_sel, .step_period_meas,
	.step_period_ref, .step_freq_match, .over_temp_in, .pump_uv_in, .driver_enable);
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gcs_pkg::*;
	logic mclk, resetn, host_is_uart, reg_wr, reg_rd, reg_rvalid, over_temp_in, pump_uv_in, short_in;
	logic encoder_a_step_in_pin, fault_event, position_event, low_velocity, velocity_regulation_en;
	logic diagnostic_pin_zero_o, diagnostic_pin_zero_oe, diagnostic_pin_one_o, diagnostic_pin_one_oe;
	logic auto_regulation_en, step_freq_match, sequencer_halt, driver_enable, encoder_n_pin_probe_en;
	logic [PROBE_SEL_W-1:0] encoder_n_pin_probe_sel;
	logic [ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [HOLD_W-1:0] standstill_current_field;
	logic signed [COIL_W-1:0] seq_coil_a, coil_a_cmd, coil_b_cmd;
	logic [PERIOD_W-1:0] step_period_meas, step_period_ref;
	logic [7:0] cnt;
	int err_count, num_checks;
	global_config_status_bank i_global_config_status_bank (.mclk, .resetn, .ce(1'b1), .host_is_uart, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .over_temp_in, .short_in, .pump_uv_in,
		.encoder_a_step_in_pin, .fault_event, .position_event, .diagnostic_pin_zero_i(1'b0),
		.diagnostic_pin_zero_o, .diagnostic_pin_zero_oe, .diagnostic_pin_one_i(1'b0), .diagnostic_pin_one_o,
		.diagnostic_pin_one_oe, .standstill_current_field, .seq_coil_a, .seq_coil_b(9'h000), .coil_a_cmd,
		.coil_b_cmd, .low_velocity, .velocity_regulation_en, .auto_regulation_en, .step_period_meas,
		.step_period_ref, .step_freq_match, .sequencer_halt, .driver_enable, .encoder_n_pin_probe_en,
		.encoder_n_pin_probe_sel);
	task summarize;
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge mclk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		if (host_is_uart) cnt++;
	endtask
	task rd(input logic [6:0] a, output logic [31:0] d);
		int i;
		@(posedge mclk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		if (reg_rvalid !== 1'b1) begin
			chk(32'h0, 32'h1);
			summarize();
		end
		d = reg_rdata;
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		{resetn, reg_wr, reg_rd, over_temp_in, pump_uv_in, encoder_a_step_in_pin} = 6'h00;
		{fault_event, position_event, low_velocity, short_in} = 4'h0;
		host_is_uart = 1'b1;
		reg_addr = 7'h00;
		reg_wdata = 32'h0;
		standstill_current_field = 5'h00;
		seq_coil_a = 9'h055;
		step_period_meas = 16'h010C;
		step_period_ref = 16'h0100;
		cnt = 8'h00;
		err_count = 0;
		num_checks = 0;
		tick(6);
		resetn = 1'b1;
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h1);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h0);
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h1);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h1);
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h0);
		rd(ADDR_WCNT, rv); chk(rv, {24'h0, cnt});
		rd(ADDR_WCNT, rv); chk(rv, {24'h0, cnt});
		rd(7'h7F, rv); chk(rv, 32'h0);
		fault_event = 1'b1;
		position_event = 1'b1;
		tick(2);
		chk({diagnostic_pin_zero_oe, diagnostic_pin_zero_o, diagnostic_pin_one_oe, diagnostic_pin_one_o}, 32'hA);
		chk(step_freq_match, 32'h1);
		step_period_meas = 16'h0120;
		tick(2);
		chk(step_freq_match, 32'h0);
		step_period_meas = 16'h010C;
		wr(ADDR_GCONF, 32'h7000);
		tick(2);
		chk({diagnostic_pin_zero_oe, diagnostic_pin_zero_o, diagnostic_pin_one_oe, diagnostic_pin_one_o}, 32'hF);
		chk(step_freq_match, 32'h0);
		fault_event = 1'b0;
		position_event = 1'b0;
		encoder_a_step_in_pin = 1'b1;
		tick(6);
		chk({diagnostic_pin_zero_oe, diagnostic_pin_zero_o, diagnostic_pin_one_oe, diagnostic_pin_one_o}, 32'hA);
		chk(sequencer_halt, 32'h0);
		wr(ADDR_GCONF, 32'h8000);
		tick(2);
		chk(sequencer_halt, 32'h1);
		encoder_a_step_in_pin = 1'b0;
		tick(6);
		chk(sequencer_halt, 32'h0);
		standstill_current_field = 5'h0F;
		wr(ADDR_TARGET, 32'h01C0_0040);
		wr(ADDR_GCONF, 32'h10000);
		tick(2);
		chk({coil_b_cmd, 7'h0, coil_a_cmd}, 32'h01E0_0020);
		chk({velocity_regulation_en, auto_regulation_en}, 32'h0);
		low_velocity = 1'b1;
		tick(1);
		chk(auto_regulation_en, 32'h1);
		standstill_current_field = 5'h1E;
		wr(ADDR_GCONF, 32'h20000);
		chk({encoder_n_pin_probe_en, encoder_n_pin_probe_sel}, 32'h6);
		over_temp_in = 1'b1;
		tick(8);
		chk(driver_enable, 32'h0);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h2);
		over_temp_in = 1'b0;
		tick(6);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h0);
		short_in = 1'b1;
		tick(8);
		chk(driver_enable, 32'h0);
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h2);
		short_in = 1'b0;
		tick(6);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h0);
		pump_uv_in = 1'b1;
		tick(8);
		chk(driver_enable, 32'h0);
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h4);
		pump_uv_in = 1'b0;
		tick(6);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h4);
		tick(2);
		chk(driver_enable, 32'h1);
		resetn = 1'b0;
		tick(2);
		resetn = 1'b1;
		cnt = 8'h00;
		rd(ADDR_GLOBAL_STATUS_FLAGS, rv); chk(rv, 32'h1);
		rd(ADDR_WCNT, rv); chk(rv, 32'h0);
		while (cnt != 8'hFF) wr(7'h7F, 32'h0);
		rd(ADDR_WCNT, rv); chk(rv, 32'hFF);
		wr(7'h7F, 32'h0);
		rd(ADDR_WCNT, rv); chk(rv, 32'h0);
		host_is_uart = 1'b0;
		wr(ADDR_GCONF, 32'h0);
		rd(ADDR_WCNT, rv); chk(rv, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
